// File: pkg/ppc_pkg.sv
/*
  package for the parallel port configuration and timing block:
  register offsets, field positions, codes and types.
  assumes a 32-bit avalon-mm register bus with word addressing in bytes.
*/
`default_nettype none
package ppc_pkg;
  localparam logic [7:0] CONTROL_OFS = 8'h00;
  localparam logic [7:0] MODE_OFS    = 8'h10;
  localparam logic [7:0] ADDR_OFS    = 8'h20;
  localparam logic [7:0] DOUT_OFS    = 8'h30;
  localparam logic [7:0] DIN_OFS     = 8'h40;
  localparam logic [7:0] XFER_OFS    = 8'h50;
  localparam logic [7:0] STAT_OFS    = 8'h60;
  // control field positions
  localparam int ON_BIT    = 15;
  localparam int STOP_IN_IDLE_BIT  = 13;
  localparam int MUX_LSB   = 11;
  localparam int TTL_BIT   = 10;
  localparam int WREN_BIT  = 9;
  localparam int RDEN_BIT  = 8;
  localparam int CSF_LSB   = 6;
  localparam int ALP_BIT   = 5;
  localparam logic [15:0] CONTROL_MASK = 16'hBFE0;
  // mode field positions
  localparam int BUSY_BIT  = 15;
  localparam int INTERRUPT_REQUEST_MODE_LSB  = 13;
  localparam int ADDRESS_STEP_MODE_LSB  = 11;
  localparam int MODE_LSB  = 8;
  localparam int SETUP_WAIT_STATES_LSB = 6;
  localparam int STROBE_WAIT_STATES_LSB = 2;
  localparam int END_WAIT_STATES_LSB = 0;
  localparam logic [15:0] MODE_MASK = 16'h7BFF;
  localparam logic [15:0] ADDR_MASK = 16'h47FF;
  localparam logic [15:0] RESET_VAL = 16'h0000;
  localparam int CS_ADDR_BIT = 14;
  localparam int PB_DIV_DEFAULT = 1;
  localparam logic [1:0] CODE_00 = 2'h0;
  localparam logic [1:0] CODE_01 = 2'h1;
  localparam logic [1:0] CODE_10 = 2'h2;
  localparam logic [1:0] CODE_11 = 2'h3;
  localparam logic [3:0] STROBE_WAIT_STATES_MIN = 4'h0;

  typedef enum logic [1:0] {
    PPC_MUX_NONE, PPC_MUX_LOW_SPLIT, PPC_MUX_FULL16, PPC_MUX_LOW8
  } ppc_mux_t;

  typedef enum logic [1:0] {
    PPC_SLV_LEGACY, PPC_SLV_ENH, PPC_MST_2, PPC_MST_1
  } ppc_mode_t;

  typedef struct packed {
    logic        cs;
    logic        rd;
    logic        wr;
    logic        al_low;
    logic        al_high;
    logic        rd_en;
    logic        wr_en;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        data_oe_b;
  } ppc_pins_t;
endpackage
`default_nettype wire

// File: rtl/ppc_port.sv
/*
  parallel port configuration and timing: control/mode registers over
  avalon-mm, master-mode transfer sequencer with wait states, slave-side
  interrupt and pointer logic.
  assumes a synchronous periph bus clock equal to clk_i, times in
  periph clock periods counted as clk_i cycles; slave pins synchronous.
*/
//
// Operation
// - enable bit off: no external accesses
// - stop-in-idle halts port during idle
// - mux select places address on pins
// - write strobe pin enable bit
// - read strobe pin enable bit
// - chip select function: cs or A14
// - latch polarity high or low
// - cs/polarity ignored when pins are address
// - busy flag readable in master modes
// - irq mode 01 per cycle, 00 none
// - irq mode 10 buffer3 or address 3
// - address step increment or decrement
// - mode 11 slave buffer pointer steps
// - A14 not stepped when chip select
// - master modes 1 and 2 strobes
// - setup wait 1 to 4 periods
// - strobe wait value plus one
// - zero strobe wait forces short phases
`timescale 1ns/1ps
`default_nettype none
module ppc_port (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        idle_i,
  input  wire logic        host_cs_i,
  input  wire logic        host_rd_i,
  input  wire logic        host_wr_i,
  input  wire logic [1:0]  host_addr_i,
  input  wire logic [7:0]  port_data_lines_i,
  output ppc_pkg::ppc_pins_t pins_o,
  output logic             irq_o
);
  typedef enum {ST_IDLE, ST_ADDR, ST_SETUP, ST_STROBE, ST_END} ppc_st_t;
  ppc_st_t st_q;

  logic [15:0] ctl_q, mode_q, addr_q;
  logic [7:0]  dout_q, din_q;
  logic [1:0]  ptr_q;
  logic [4:0]  cnt_q;
  logic        hi_q, wr_q, busy_q, wait_q, irq_q;
  ppc_pkg::ppc_pins_t pins_q;
  logic [31:0] rdata_q;

  wire logic on     = ctl_q[ppc_pkg::ON_BIT];
  wire logic run    = on & ~(ctl_q[ppc_pkg::STOP_IN_IDLE_BIT] & idle_i);
  wire logic [1:0] mux  = ctl_q[ppc_pkg::MUX_LSB +: 2];
  wire logic [1:0] chip_select_function  = ctl_q[ppc_pkg::CSF_LSB +: 2];
  wire logic [1:0] interrupt_request_mode = mode_q[ppc_pkg::INTERRUPT_REQUEST_MODE_LSB +: 2];
  wire logic [1:0] address_step_mode = mode_q[ppc_pkg::ADDRESS_STEP_MODE_LSB +: 2];
  wire logic [1:0] pm   = mode_q[ppc_pkg::MODE_LSB +: 2];
  wire logic [1:0] wb   = mode_q[ppc_pkg::SETUP_WAIT_STATES_LSB +: 2];
  wire logic [3:0] wm   = mode_q[ppc_pkg::STROBE_WAIT_STATES_LSB +: 4];
  wire logic [1:0] we   = mode_q[ppc_pkg::END_WAIT_STATES_LSB +: 2];
  wire logic master = pm[1];
  wire logic cs_fn  = (chip_select_function == ppc_pkg::CODE_10);
  wire logic addr_latch_polarity    = ctl_q[ppc_pkg::ALP_BIT];
  wire logic short_w = (wm == ppc_pkg::STROBE_WAIT_STATES_MIN);
  wire logic [4:0] setup_len = short_w ? 5'h01 : {3'h0, wb} + 5'h01;
  wire logic [4:0] end_len   = short_w ? (wr_q ? 5'h01 : 5'h00)
                                       : {3'h0, we};
  wire logic [4:0] strobe_len = {1'b0, wm} + 5'h01;

  // bus access decode; waitrequest idles high and drops for the one edge
  // at which an access completes, so a write lands there and read data
  // captured one edge earlier already stands in a flop
  wire logic req    = avs_read_i | avs_write_i;
  wire logic wr_acc = avs_write_i & ~wait_q;
  wire logic [7:0] ofs = avs_address_i;
  wire logic [15:0] wd = avs_writedata_i[15:0];
  wire logic [15:0] be = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire logic start = wr_acc & master & run & ~busy_q &
                     ((ofs == ppc_pkg::DOUT_OFS) | (ofs == ppc_pkg::XFER_OFS));

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end
  assign avs_waitrequest_o = wait_q;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctl_q  <= ppc_pkg::RESET_VAL;
      mode_q <= ppc_pkg::RESET_VAL;
      dout_q <= 8'h00;
    end else if (wr_acc) begin
      case (ofs)
        ppc_pkg::CONTROL_OFS: begin
          ctl_q <= (ctl_q & ~be) | (wd & be & ppc_pkg::CONTROL_MASK);
        end
        ppc_pkg::MODE_OFS: begin
          mode_q <= (mode_q & ~be) | (wd & be & ppc_pkg::MODE_MASK);
        end
        ppc_pkg::DOUT_OFS: begin
          if (avs_byteenable_i[0]) begin
            dout_q <= wd[7:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      case (ofs)
        ppc_pkg::CONTROL_OFS: rdata_q <= {16'h0000, ctl_q};
        ppc_pkg::MODE_OFS:
          rdata_q <= {16'h0000, busy_q & master, mode_q[14:0]};
        ppc_pkg::ADDR_OFS: rdata_q <= {16'h0000, addr_q};
        ppc_pkg::DOUT_OFS: rdata_q <= {24'h000000, dout_q};
        ppc_pkg::DIN_OFS:  rdata_q <= {24'h000000, din_q};
        ppc_pkg::STAT_OFS: rdata_q <= {29'h0, ptr_q, busy_q};
        default:           rdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata_o = rdata_q;

  // address register; stepping only on a completed master cycle
  wire logic cyc_done = busy_q & (((st_q == ST_STROBE) & (cnt_q == 5'h01)
                         & (end_len == 5'h00)) |
                        ((st_q == ST_END) & (cnt_q == 5'h01)));
  wire logic a14_step = ~cs_fn;
  wire logic [9:0] step_in = {a14_step & addr_q[ppc_pkg::CS_ADDR_BIT],
                              addr_q[10:2]};
  wire logic [9:0] step_up = step_in + 10'h001;
  wire logic [9:0] step_dn = step_in - 10'h001;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      addr_q <= ppc_pkg::RESET_VAL;
    end else if (wr_acc && ofs == ppc_pkg::ADDR_OFS) begin
      addr_q <= (addr_q & ~be) | (wd & be & ppc_pkg::ADDR_MASK);
    end else if (cyc_done && address_step_mode == ppc_pkg::CODE_01) begin
      addr_q[10:2] <= step_up[8:0];
      if (a14_step) addr_q[14] <= step_up[9];
    end else if (cyc_done && address_step_mode == ppc_pkg::CODE_10) begin
      addr_q[10:2] <= step_dn[8:0];
      if (a14_step) addr_q[14] <= step_dn[9];
    end
  end

  // master sequencer
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 5'h00;
      hi_q <= 1'b0;
      wr_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (!run) begin
      st_q <= ST_IDLE;
      busy_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            busy_q <= 1'b1;
            wr_q <= (ofs == ppc_pkg::DOUT_OFS);
            hi_q <= (mux == ppc_pkg::CODE_10);
            cnt_q <= setup_len;
            st_q <= (mux == ppc_pkg::CODE_00) ? ST_SETUP : ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (cnt_q == 5'h01) begin
            cnt_q <= setup_len;
            if (hi_q) hi_q <= 1'b0;
            else st_q <= ST_SETUP;
          end else cnt_q <= cnt_q - 5'h01;
        end
        ST_SETUP: begin
          if (cnt_q == 5'h01) begin
            cnt_q <= strobe_len;
            st_q <= ST_STROBE;
          end else cnt_q <= cnt_q - 5'h01;
        end
        ST_STROBE: begin
          if (cnt_q == 5'h01) begin
            cnt_q <= end_len;
            if (end_len == 5'h00) begin
              st_q <= ST_IDLE;
              busy_q <= 1'b0;
            end else st_q <= ST_END;
          end else cnt_q <= cnt_q - 5'h01;
        end
        ST_END: begin
          if (cnt_q == 5'h01) begin
            st_q <= ST_IDLE;
            busy_q <= 1'b0;
          end else cnt_q <= cnt_q - 5'h01;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // read data capture and slave side
  wire logic slv_acc = run & ~master & host_cs_i & (host_rd_i | host_wr_i);
  logic slv_acc_q;
  logic cap_q;
  // the strobe pin lags the sequencer by one flop, so read data is taken
  // one edge after the last strobe period, while the pin still stands
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      din_q <= 8'h00;
      ptr_q <= 2'h0;
      slv_acc_q <= 1'b0;
      cap_q <= 1'b0;
    end else begin
      slv_acc_q <= slv_acc;
      cap_q <= busy_q & ~wr_q & (st_q == ST_STROBE) & (cnt_q == 5'h01);
      if (cap_q) begin
        din_q <= port_data_lines_i;
      end else if (slv_acc && !slv_acc_q && host_wr_i) begin
        din_q <= port_data_lines_i;
      end
      if (slv_acc && !slv_acc_q && pm == ppc_pkg::CODE_00 &&
          address_step_mode == ppc_pkg::CODE_11) begin
        ptr_q <= ptr_q + 2'h1;
      end
    end
  end

  wire logic slv_edge = slv_acc & ~slv_acc_q;
  wire logic buf3 = (pm == ppc_pkg::CODE_00) ? (ptr_q == 2'h3)
                                             : (host_addr_i == 2'h3);
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      irq_q <= 1'b0;
    end else begin
      case (interrupt_request_mode)
        ppc_pkg::CODE_01: irq_q <= cyc_done | slv_edge;
        ppc_pkg::CODE_10: irq_q <= slv_edge & buf3;
        default:          irq_q <= 1'b0;
      endcase
    end
  end
  assign irq_o = irq_q;

  // pin drive
  wire logic strobe = busy_q & (st_q == ST_STROBE);
  wire logic in_addr = busy_q & (st_q == ST_ADDR);
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pins_q <= '0;
      pins_q.data_oe_b <= 1'b1;
    end else begin
      pins_q.rd_en <= run & ctl_q[ppc_pkg::RDEN_BIT];
      pins_q.wr_en <= run & ctl_q[ppc_pkg::WREN_BIT];
      pins_q.addr <= {1'b0, addr_q[14:0]};
      if (cs_fn) pins_q.addr[14] <= 1'b0;
      pins_q.cs <= cs_fn & busy_q;
      if (pm == ppc_pkg::CODE_11) begin
        pins_q.rd <= busy_q & ~wr_q;
        pins_q.wr <= strobe;
      end else begin
        pins_q.rd <= strobe & ~wr_q;
        pins_q.wr <= strobe & wr_q;
      end
      pins_q.al_low  <= (mux == ppc_pkg::CODE_00) ? 1'b0 :
                        ((in_addr & ~hi_q) ~^ addr_latch_polarity);
      pins_q.al_high <= (mux == ppc_pkg::CODE_00) ? 1'b0 :
                        ((in_addr & hi_q) ~^ addr_latch_polarity);
      pins_q.data <= in_addr ? (hi_q ? addr_q[15:8] : addr_q[7:0]) : dout_q;
      pins_q.data_oe_b <= ~(in_addr | (busy_q & wr_q & st_q != ST_IDLE));
    end
  end
  assign pins_o = pins_q;

  property busy_len_p;
    @(posedge clk_i) disable iff (!rst_b_i)
      start |=> busy_q [*2];
  endproperty
  busy_hold_a: assert property (busy_len_p)
    else $error("busy did not hold after start");
  off_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !on |=> !busy_q)
    else $error("port busy while disabled");
  idle_stop_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (ctl_q[ppc_pkg::STOP_IN_IDLE_BIT] & idle_i) |=> !busy_q)
    else $error("port ran in idle");
  irq_none_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (interrupt_request_mode == ppc_pkg::CODE_00) && $stable(interrupt_request_mode) |=> !irq_q)
    else $error("interrupt in mode 00");
  strobe_len_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (wm == 4'h0) && $rose(strobe) |=> !strobe)
    else $error("strobe longer than one period");
  a14_keep_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      cyc_done && cs_fn |=> $stable(addr_q[14]))
    else $error("a14 stepped while chip select");
  step_up_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      cyc_done && address_step_mode == ppc_pkg::CODE_01 && !wr_acc
      |=> addr_q[10:2] == $past(addr_q[10:2]) + 9'h001)
    else $error("address did not increment");
  rd_pin_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !ctl_q[ppc_pkg::RDEN_BIT] |=> !pins_q.rd_en)
    else $error("read strobe pin enabled while off");
  wr_pin_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !ctl_q[ppc_pkg::WREN_BIT] |=> !pins_q.wr_en)
    else $error("write strobe pin enabled while off");
  wait_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one edge");
  busy_slave_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !master && ofs == ppc_pkg::MODE_OFS
      |=> !rdata_q[ppc_pkg::BUSY_BIT])
    else $error("busy flag read high in slave mode");
  cs_pin_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !cs_fn |=> !pins_q.cs)
    else $error("chip select driven while address line");
  a14_pin_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      cs_fn |=> !pins_q.addr[ppc_pkg::CS_ADDR_BIT])
    else $error("address bit 14 driven while chip select");
  latch_none_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      mux == ppc_pkg::CODE_00 |=> !pins_q.al_low && !pins_q.al_high)
    else $error("latch strobe driven without multiplexing");
  slave_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !master && !busy_q |=> !pins_q.rd && !pins_q.wr)
    else $error("strobe driven in slave mode");
  read_oe_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      busy_q && !wr_q && st_q == ST_STROBE |=> pins_q.data_oe_b)
    else $error("data lines driven during a read strobe");
  irq_rsvd_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      interrupt_request_mode == ppc_pkg::CODE_11 |=> !irq_q)
    else $error("interrupt in reserved mode");
  step_down_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      cyc_done && address_step_mode == ppc_pkg::CODE_10 && !wr_acc
      |=> addr_q[10:2] == $past(addr_q[10:2]) - 9'h001)
    else $error("address did not decrement");

  // last strobe period of a transfer; the end phase, if any, follows
  sequence strobe_last_s;
    busy_q && st_q == ST_STROBE && cnt_q == 5'h01;
  endsequence
  // a read with the shortest strobe has no end wait at all
  property read_end_p;
    @(posedge clk_i) disable iff (!rst_b_i)
      (!wr_q && short_w) ##0 strobe_last_s |=> !busy_q;
  endproperty
  read_end_a: assert property (read_end_p)
    else $error("read end wait not zero");
  // a write with the shortest strobe keeps one end period
  property write_end_p;
    @(posedge clk_i) disable iff (!rst_b_i)
      (run && wr_q && short_w) ##0 strobe_last_s |=> st_q == ST_END;
  endproperty
  write_end_a: assert property (write_end_p)
    else $error("write end wait not one period");
endmodule // ppc_port
`default_nettype wire

// File: sim/parallel_port_config_timing_bench.sv
/*
  testbench: register access, master timing, address stepping, pin
  functions and interrupts of the parallel port.
  assumes the peer model stands on the pins and answers reads.
*/
`timescale 1ns/1ps
`default_nettype none
module parallel_port_config_timing_bench;
  logic               clk_i;
  logic               rst_b_i;
  logic [7:0]         avs_address_i;
  logic               avs_read_i;
  logic               avs_write_i;
  logic [31:0]        avs_writedata_i;
  logic [31:0]        avs_readdata_o;
  logic               avs_waitrequest_o;
  logic               idle_i;
  logic               host_cs;
  logic               host_rd;
  logic               host_wr;
  logic [1:0]         host_addr;
  logic [7:0]         pdata;
  ppc_pkg::ppc_pins_t pins_o;
  logic               irq_o;
  logic [15:0]        rd_q;
  logic               seen_cs;
  logic               seen_ab;
  int                 errors;
  int                 comparisons;
  int                 icnt;
  int                 su;
  int                 wd;
  int                 base;

  ppc_port i_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'h3),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .idle_i(idle_i), .host_cs_i(host_cs), .host_rd_i(host_rd),
    .host_wr_i(host_wr), .host_addr_i(host_addr),
    .port_data_lines_i(pdata), .pins_o(pins_o), .irq_o(irq_o));
  ppc_peer_model i_peer (
    .clk_i(clk_i), .pins_i(pins_o), .data_o(pdata), .cs_o(host_cs),
    .rd_o(host_rd), .wr_o(host_wr), .addr_o(host_addr));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (irq_o === 1'b1)
      icnt++;
  end

  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  // the request stands from the call, just after a rising or a falling edge, until the rising
  // edge at which waitrequest is seen low; read data is taken there
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= {16'h0000, d};
    avs_read_i <= !w;
    avs_write_i <= w;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 50) begin
      errors++;
      $display("ERROR waitrequest expected 0 seen 1");
      wrap_up();
    end
    rd_q = avs_readdata_o[15:0];
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  function automatic logic [15:0] md(input int interrupt_request_mode, address_step_mode, mode, wb,
                                     input logic [3:0] wm);
    return {1'b0, interrupt_request_mode[1:0], address_step_mode[1:0], 1'b0, mode[1:0], wb[1:0], wm,
            2'b00};
  endfunction
  // start a transfer, count cycles before and during the chosen strobe
  task automatic xfer(input logic [7:0] ofs, input logic use_rd);
    logic s;
    bus(1'b1, ofs, 16'h00A5);
    su = 0;
    wd = 0;
    seen_cs = 1'b0;
    seen_ab = 1'b0;
    repeat (80) begin
      @(negedge clk_i);
      s = use_rd ? pins_o.rd : pins_o.wr;
      if (s === 1'b1) begin
        wd++;
        seen_cs = seen_cs | pins_o.cs;
      end else if (wd == 0) begin
        su++;
        if (pins_o.data_oe_b === 1'b0 && pins_o.data === 8'h55)
          seen_ab = 1'b1;
      end
    end
  endtask

  initial begin
    logic [7:0]  ofs [3];
    logic [15:0] msk [3];
    ofs = '{ppc_pkg::CONTROL_OFS, ppc_pkg::MODE_OFS, 8'h74};
    msk = '{ppc_pkg::CONTROL_MASK, ppc_pkg::MODE_MASK, 16'h0000};
    errors = 0;
    comparisons = 0;
    icnt = 0;
    rst_b_i = 1'b0;
    avs_address_i = 8'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    idle_i = 1'b0;
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    foreach (ofs[i]) begin
      bus(1'b0, ofs[i], 16'h0000);
      chk("reset value", 16'h0000, rd_q);
      bus(1'b1, ofs[i], 16'hFFFF);
      bus(1'b0, ofs[i], 16'h0000);
      chk("access", msk[i], rd_q);
    end
    chk("pin enables", 16'h3, {14'h0, pins_o.wr_en, pins_o.rd_en});
    bus(1'b1, ppc_pkg::CONTROL_OFS, 16'h0000);
    // one idle cycle already follows the write that turns the port off
    bus(1'b1, ppc_pkg::MODE_OFS, md(0, 0, 2, 0, 4'h3));
    chk("pin enables off", 16'h0, {14'h0, pins_o.wr_en, pins_o.rd_en});
    xfer(ppc_pkg::DOUT_OFS, 1'b0);
    chk("strobe while off", 16'h0, 16'(wd));
    $display("test registers done");
    bus(1'b1, ppc_pkg::CONTROL_OFS, 16'h8380);
    for (int b = 0; b < 4; b++) begin
      bus(1'b1, ppc_pkg::MODE_OFS, md(0, 0, 2, 2'(b), 4'h3));
      xfer(ppc_pkg::DOUT_OFS, 1'b0);
      if (b == 0)
        base = su;
      chk("setup", 16'(base + b), 16'(su));
      chk("strobe", 16'h4, 16'(wd));
    end
    chk("chip select", 16'h1, {15'h0, seen_cs});
    bus(1'b1, ppc_pkg::MODE_OFS, md(0, 0, 2, 0, 4'hF));
    xfer(ppc_pkg::DOUT_OFS, 1'b0);
    chk("long strobe", 16'h10, 16'(wd));
    bus(1'b1, ppc_pkg::MODE_OFS, md(0, 0, 2, 3, 4'h0));
    xfer(ppc_pkg::DOUT_OFS, 1'b0);
    chk("short setup", 16'(base), 16'(su));
    chk("short strobe", 16'h1, 16'(wd));
    xfer(ppc_pkg::XFER_OFS, 1'b1);
    chk("read strobe", 16'h1, 16'(wd));
    bus(1'b0, ppc_pkg::DIN_OFS, 16'h0000);
    chk("read data", 16'h003C, rd_q);
    bus(1'b1, ppc_pkg::MODE_OFS, md(0, 0, 2, 0, 4'hF));
    bus(1'b1, ppc_pkg::DOUT_OFS, 16'h005A);
    bus(1'b0, ppc_pkg::MODE_OFS, 16'h0000);
    chk("busy", md(0, 0, 2, 0, 4'hF) | 16'h8000, rd_q);
    for (int n = 0; n < 20 && rd_q[15] !== 1'b0; n++)
      bus(1'b0, ppc_pkg::MODE_OFS, 16'h0000);
    chk("busy falls", 16'h0, {15'h0, rd_q[15]});
    bus(1'b1, ppc_pkg::MODE_OFS, md(0, 0, 3, 0, 4'h3));
    xfer(ppc_pkg::XFER_OFS, 1'b0);
    chk("enable strobe", 16'h4, 16'(wd));
    $display("test timing done");
    bus(1'b1, ppc_pkg::CONTROL_OFS, 16'hA380);
    bus(1'b1, ppc_pkg::MODE_OFS, md(0, 0, 2, 0, 4'h3));
    idle_i <= 1'b1;
    xfer(ppc_pkg::DOUT_OFS, 1'b0);
    chk("idle stop", 16'h0, 16'(wd));
    bus(1'b1, ppc_pkg::CONTROL_OFS, 16'h8380);
    xfer(ppc_pkg::DOUT_OFS, 1'b0);
    chk("idle run", 16'h4, 16'(wd));
    idle_i <= 1'b0;
    bus(1'b1, ppc_pkg::ADDR_OFS, 16'h0010);
    bus(1'b1, ppc_pkg::MODE_OFS, md(0, 1, 2, 0, 4'h0));
    xfer(ppc_pkg::DOUT_OFS, 1'b0);
    bus(1'b0, ppc_pkg::ADDR_OFS, 16'h0000);
    chk("stepped", 16'h0014, rd_q);
    bus(1'b1, ppc_pkg::MODE_OFS, md(0, 2, 2, 0, 4'h0));
    xfer(ppc_pkg::DOUT_OFS, 1'b0);
    bus(1'b0, ppc_pkg::ADDR_OFS, 16'h0000);
    chk("stepped back", 16'h0010, rd_q);
    bus(1'b1, ppc_pkg::ADDR_OFS, 16'h0000);
    xfer(ppc_pkg::DOUT_OFS, 1'b0);
    bus(1'b0, ppc_pkg::ADDR_OFS, 16'h0000);
    chk("a14 kept", 16'h0, {15'h0, rd_q[14]});
    bus(1'b1, ppc_pkg::MODE_OFS, md(0, 0, 2, 0, 4'h3));
    bus(1'b1, ppc_pkg::ADDR_OFS, 16'h0155);
    xfer(ppc_pkg::DOUT_OFS, 1'b0);
    bus(1'b0, ppc_pkg::ADDR_OFS, 16'h0000);
    chk("held", 16'h0155, rd_q);
    bus(1'b1, ppc_pkg::CONTROL_OFS, 16'h8B00);
    @(negedge clk_i);
    chk("latch idle low", 16'h1, {15'h0, pins_o.al_low});
    xfer(ppc_pkg::DOUT_OFS, 1'b0);
    chk("addr on data", 16'h1, {15'h0, seen_ab});
    chk("addr high", 16'h1, {13'h0, pins_o.addr[10:8]});
    bus(1'b1, ppc_pkg::CONTROL_OFS, 16'h8B20);
    @(negedge clk_i);
    chk("latch idle high", 16'h0, {15'h0, pins_o.al_low});
    bus(1'b1, ppc_pkg::CONTROL_OFS, 16'h8300);
    @(negedge clk_i);
    chk("latch unused", 16'h0, {15'h0, pins_o.al_low});
    $display("test address done");
    bus(1'b1, ppc_pkg::MODE_OFS, md(1, 0, 2, 0, 4'h0));
    icnt = 0;
    xfer(ppc_pkg::DOUT_OFS, 1'b0);
    chk("irq per cycle", 16'h1, 16'(icnt));
    bus(1'b1, ppc_pkg::MODE_OFS, md(0, 0, 2, 0, 4'h0));
    icnt = 0;
    xfer(ppc_pkg::DOUT_OFS, 1'b0);
    chk("no irq", 16'h0, 16'(icnt));
    bus(1'b1, ppc_pkg::MODE_OFS, md(2, 0, 1, 0, 4'h0));
    icnt = 0;
    i_peer.host(1'b1, 2'h3);
    i_peer.host(1'b0, 2'h1);
    chk("irq address 3", 16'h1, 16'(icnt));
    bus(1'b1, ppc_pkg::MODE_OFS, md(2, 3, 0, 0, 4'h0));
    icnt = 0;
    i_peer.host(1'b1, 2'h0);
    i_peer.host(1'b1, 2'h0);
    bus(1'b0, ppc_pkg::STAT_OFS, 16'h0000);
    chk("buffer pointer", 16'h0004, rd_q);
    i_peer.host(1'b1, 2'h0);
    i_peer.host(1'b1, 2'h0);
    chk("irq buffer 3", 16'h1, 16'(icnt));
    $display("test interrupts done");
    wrap_up();
  end
endmodule // parallel_port_config_timing_bench
`default_nettype wire

// File: sim/ppc_peer_model.sv
/*
  partner model: a parallel memory answering the port in master modes
  and a host processor driving it in slave modes.
  assumes clk_i is the port clock and all strobes are active high.
*/
`timescale 1ns/1ps
`default_nettype none
module ppc_peer_model #(
  parameter logic [7:0] PEER_BYTE = 8'h3C
) (
  input  wire logic               clk_i,
  input  wire ppc_pkg::ppc_pins_t pins_i,
  output logic [7:0]              data_o,
  output logic                    cs_o,
  output logic                    rd_o,
  output logic                    wr_o,
  output logic [1:0]              addr_o
);
  logic [7:0] last_q;
  logic       drive;
  initial begin
    last_q = 8'h00;
    cs_o = 1'b0;
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 2'h0;
  end
  // answer only while strobed and the port has let go of the lines
  assign drive = (pins_i.rd | pins_i.wr) & pins_i.data_oe_b;
  // a released bus keeps toggling so stale data never passes as a read
  always_comb begin
    if (wr_o)
      data_o = PEER_BYTE;
    else if (drive)
      data_o = PEER_BYTE ^ pins_i.addr[7:0];
    else
      data_o = ~last_q;
  end
  always @(posedge clk_i) begin
    last_q <= data_o;
  end
  task automatic host(input logic w, input logic [1:0] a);
    cs_o <= 1'b1;
    addr_o <= a;
    rd_o <= !w;
    wr_o <= w;
    repeat (3) @(posedge clk_i);
    cs_o <= 1'b0;
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
endmodule // ppc_peer_model
`default_nettype wire
